// >>> src/cdff_bank.sv
// What this block does
// - Plain flop copies data to output at each rising sample edge, else holds.
// - Each variant starts at its power-up value, zero by default for the plain, gated and clear variants.
// - The preset variant defaults its power-up value to one.
// - Gated, clear and preset variants load data only while capture permit is high.
// - Low clear input wins over data and permit, forcing output zero.
// - Unclocked clear forces zero without waiting for a sample edge.
// - Clocked clear forces zero at next sample edge, even with permit low.
// - Clear timing choice is unclocked or clocked, unclocked by default.
// - Normal capture needs permit high and clear or preset deasserted.
// - Any power-up value works together with unclocked clear or preset.
// - Low preset input wins over data and permit, forcing output one.
// - Unclocked preset sets output high without waiting for a sample edge.
// - Clocked preset sets output one at next sample edge, regardless of permit.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cdff_cfg.svh"

module cdff_bank #(
   parameter logic PLAIN_POWER_UP = 1'b0,
   parameter logic GATE_POWER_UP = 1'b0,
   parameter logic CLEAR_POWER_UP = 1'b0,
   parameter logic PRESET_POWER_UP = 1'b1,
   parameter string CLEAR_TIMING = "unclocked",
   parameter string PRESET_TIMING = "unlocked"
) (
   // System
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flop outputs
   output logic plain_q,
   output logic gate_q,
   output logic clear_q,
   output logic preset_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic [31:0] ctrl_reg;
   logic [`CDFF_DIV_WIDTH-1:0] div_reg;
   logic access_phase;
   logic wr_commit;
   logic fire_now;
   logic sample_edge;
   logic [31:0] rd_value;
   logic rd_hit;

   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
      return addr == ofs;
   endfunction

   // First access cycle raises pready; the commit edge is the one that sees it high
   assign access_phase = psel && penable;
   assign wr_commit = access_phase && pready && pwrite;
   assign fire_now = wr_commit && reg_hit(paddr, `CDFF_EDGE_OFS) && pwdata[`CDFF_EDGE_FIRE_BIT];

   always_comb begin
      rd_value = 32'h0000_0000;
      rd_hit = 1'b1;
      if (reg_hit(paddr, `CDFF_CTRL_OFS)) begin
         rd_value = ctrl_reg;
      end else if (reg_hit(paddr, `CDFF_EDGE_OFS)) begin
         rd_value = 32'h0000_0000;
      end else if (reg_hit(paddr, `CDFF_DIV_OFS)) begin
         rd_value = 32'(div_reg);
      end else if (reg_hit(paddr, `CDFF_STATUS_OFS)) begin
         rd_value[`CDFF_STATUS_Q_MSB:`CDFF_STATUS_Q_LSB] = {preset_q, clear_q, gate_q, plain_q};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Answer after one wait state, then drop so back-to-back transfers see a fresh pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access_phase && !pready;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access_phase && !pready) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_value;
         pslverr <= !rd_hit;
      end else begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CDFF_CTRL_RESET;
      end else if (wr_commit && reg_hit(paddr, `CDFF_CTRL_OFS)) begin
         ctrl_reg <= pwdata & `CDFF_CTRL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= `CDFF_DIV_RESET;
      end else if (wr_commit && reg_hit(paddr, `CDFF_DIV_OFS)) begin
         div_reg <= pwdata[`CDFF_DIV_WIDTH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sample edge source: software strobe or periodic divider

   cdff_edge_div #(
      .DIV_WIDTH(`CDFF_DIV_WIDTH)
   ) u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .period(div_reg),
      .fire_now(fire_now),
      .sample_edge(sample_edge)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // The four variants, all from one flop module

   logic [3:0] data_bits;
   logic [2:0] permit_bits;

   assign data_bits = ctrl_reg[`CDFF_CTRL_DATA_MSB:`CDFF_CTRL_DATA_LSB];
   assign permit_bits = ctrl_reg[`CDFF_CTRL_PERMIT_MSB:`CDFF_CTRL_PERMIT_LSB];

   cdff_flop #(
      .HAS_PERMIT(1'b0),
      .HAS_CLEAR(1'b0),
      .HAS_PRESET(1'b0),
      .POWER_UP_VALUE(PLAIN_POWER_UP),
      .TIMING("unclocked")
   ) u_plain (
      .pclk(pclk),
      .presetn(presetn),
      .sample_edge(sample_edge),
      .data_in(data_bits[0]),
      .capture_permit(1'b1),
      .clear_low(1'b1),
      .preset_low(1'b1),
      .q(plain_q)
   );

   cdff_flop #(
      .HAS_PERMIT(1'b1),
      .HAS_CLEAR(1'b0),
      .HAS_PRESET(1'b0),
      .POWER_UP_VALUE(GATE_POWER_UP),
      .TIMING("unclocked")
   ) u_gate (
      .pclk(pclk),
      .presetn(presetn),
      .sample_edge(sample_edge),
      .data_in(data_bits[1]),
      .capture_permit(permit_bits[0]),
      .clear_low(1'b1),
      .preset_low(1'b1),
      .q(gate_q)
   );

   cdff_flop #(
      .HAS_PERMIT(1'b1),
      .HAS_CLEAR(1'b1),
      .HAS_PRESET(1'b0),
      .POWER_UP_VALUE(CLEAR_POWER_UP),
      .TIMING(CLEAR_TIMING)
   ) u_clear (
      .pclk(pclk),
      .presetn(presetn),
      .sample_edge(sample_edge),
      .data_in(data_bits[2]),
      .capture_permit(permit_bits[1]),
      .clear_low(ctrl_reg[`CDFF_CTRL_CLEAR_BIT]),
      .preset_low(1'b1),
      .q(clear_q)
   );

   cdff_flop #(
      .HAS_PERMIT(1'b1),
      .HAS_CLEAR(1'b0),
      .HAS_PRESET(1'b1),
      .POWER_UP_VALUE(PRESET_POWER_UP),
      .TIMING(PRESET_TIMING)
   ) u_preset (
      .pclk(pclk),
      .presetn(presetn),
      .sample_edge(sample_edge),
      .data_in(data_bits[3]),
      .capture_permit(permit_bits[2]),
      .clear_low(1'b1),
      .preset_low(ctrl_reg[`CDFF_CTRL_PRESET_BIT]),
      .q(preset_q)
   );

endmodule // cdff_bank

`default_nettype wire

// >>> inc/cdff_cfg.svh
`ifndef CDFF_CFG_SVH
`define CDFF_CFG_SVH

// Register byte offsets
`define CDFF_CTRL_OFS 12'h000
`define CDFF_EDGE_OFS 12'h004
`define CDFF_DIV_OFS 12'h008
`define CDFF_STATUS_OFS 12'h00C

// Control register fields
`define CDFF_CTRL_DATA_LSB 0
`define CDFF_CTRL_DATA_MSB 3
`define CDFF_CTRL_PERMIT_LSB 4
`define CDFF_CTRL_PERMIT_MSB 6
`define CDFF_CTRL_CLEAR_BIT 8
`define CDFF_CTRL_PRESET_BIT 9
`define CDFF_CTRL_MASK 32'h0000_037F
// Clear and preset inputs idle high, nothing permitted, data low
`define CDFF_CTRL_RESET 32'h0000_0300

// Edge register: writing one here makes one sample edge
`define CDFF_EDGE_FIRE_BIT 0

// Divider register: period of automatic sample edges in pclk cycles, zero stops them
`define CDFF_DIV_WIDTH 16
`define CDFF_DIV_RESET 16'h0000

// Status register: stored values of the four flops
`define CDFF_STATUS_Q_LSB 0
`define CDFF_STATUS_Q_MSB 3

`endif

// >>> inc/cdff_pkg.sv
package cdff_pkg;

   // Assertion timing of clear or preset
   typedef enum logic {
      CDFF_UNCLOCKED = 1'b0,
      CDFF_CLOCKED = 1'b1
   } cdff_timing_t;

   // The older spelling "unlocked" is accepted as the asynchronous setting
   function automatic cdff_timing_t cdff_timing_of(input string name);
      if (name == "clocked") begin
         return CDFF_CLOCKED;
      end
      return CDFF_UNCLOCKED;
   endfunction

endpackage

// >>> src/cdff_flop.sv
`timescale 1ns/1ps
`default_nettype none

module cdff_flop #(
   parameter bit HAS_PERMIT = 1'b0,
   parameter bit HAS_CLEAR = 1'b0,
   parameter bit HAS_PRESET = 1'b0,
   parameter logic POWER_UP_VALUE = 1'b0,
   parameter string TIMING = "unclocked"
) (
   // System
   input wire logic pclk,
   input wire logic presetn,
   // Flop inputs
   input wire logic sample_edge,
   input wire logic data_in,
   input wire logic capture_permit,
   input wire logic clear_low,
   input wire logic preset_low,
   // Stored value
   output logic q
);

   localparam cdff_pkg::cdff_timing_t MODE = cdff_pkg::cdff_timing_of(TIMING);

   logic clear_act;
   logic preset_act;
   logic load_act;

   // Unclocked mode acts on the next pclk edge, without waiting for a sample edge
   assign clear_act = HAS_CLEAR && !clear_low &&
      (MODE == cdff_pkg::CDFF_UNCLOCKED || sample_edge);
   assign preset_act = HAS_PRESET && !preset_low &&
      (MODE == cdff_pkg::CDFF_UNCLOCKED || sample_edge);
   assign load_act = sample_edge && (!HAS_PERMIT || capture_permit);

   // Power-up value is loaded by the reset of any variant, so any value works with either timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= POWER_UP_VALUE;
      end else if (clear_act) begin
         q <= 1'b0;
      end else if (preset_act) begin
         q <= 1'b1;
      end else if (load_act) begin
         q <= data_in;
      end
   end

endmodule // cdff_flop

`default_nettype wire

// >>> src/cdff_edge_div.sv
`timescale 1ns/1ps
`default_nettype none

module cdff_edge_div #(
   parameter int DIV_WIDTH = 16
) (
   // System
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic [DIV_WIDTH-1:0] period,
   input wire logic fire_now,
   // One-cycle sample edge
   output logic sample_edge
);

   logic [DIV_WIDTH-1:0] count_reg;
   logic wrap;

   assign wrap = (period != '0) && (count_reg >= period - DIV_WIDTH'(1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
      end else if (wrap || period == '0) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + DIV_WIDTH'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_edge <= 1'b0;
      end else begin
         sample_edge <= wrap || fire_now;
      end
   end

endmodule // cdff_edge_div

`default_nettype wire

// >>> dv/cdff_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cdff_bank_monitor #(
   parameter string CLEAR_TIMING = "unclocked",
   parameter string PRESET_TIMING = "unlocked"
) (
   // System
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Flops
   input wire logic plain_q,
   input wire logic gate_q,
   input wire logic clear_q,
   input wire logic preset_q
);
   logic [9:0] sh_reg;
   logic wr;
   logic ewr;
   logic div_on_reg;
   // Anything but "clocked" acts without a sample edge
   localparam bit CLR_NOW = (CLEAR_TIMING != "clocked");
   localparam bit PRE_NOW = (PRESET_TIMING != "clocked");
   assign wr = psel && penable && pready && pwrite;
   assign ewr = wr && paddr == 12'h004 && pwdata[0];
   // Mirror of the control word, so outputs can be judged without the body
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_reg <= 10'h300;
      end else if (wr && paddr == 12'h000) begin
         sh_reg <= pwdata[9:0] & 10'h37F;
      end
   end
   // Periodic edges may move the outputs too, so track whether the divider runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_on_reg <= 1'b0;
      end else if (wr && paddr == 12'h008) begin
         div_on_reg <= pwdata[15:0] != 16'h0000;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   sequence s_fire;
      ewr ##2 1'b1;
   endsequence
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("ready late");
   property p_once; pready |=> !pready; endproperty
   a_once: assert property (p_once) else $error("ready stuck");
   property p_err; pready && paddr > 12'h00C |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no slave error");
   property p_ok; pready && paddr == 12'h000 |-> !pslverr && prdata[31:10] == 0; endproperty
   a_ok: assert property (p_ok) else $error("control answer wrong");
   property p_clr; CLR_NOW && !sh_reg[8] |=> !clear_q; endproperty
   a_clr: assert property (p_clr) else $error("clear not forced");
   property p_pre; PRE_NOW && !sh_reg[9] |=> preset_q; endproperty
   a_pre: assert property (p_pre) else $error("preset not forced");
   property p_hold; $changed(plain_q) |-> $past(ewr, 2) || $past(div_on_reg, 2); endproperty
   a_hold: assert property (p_hold) else $error("plain moved alone");
   property p_load;
      s_fire |-> plain_q == $past(sh_reg[0]) && gate_q == ($past(sh_reg[4]) ? $past(sh_reg[1]) : $past(gate_q));
   endproperty
   a_load: assert property (p_load) else $error("load wrong");
   property p_csync; !CLR_NOW && ewr && !sh_reg[8] |-> ##2 !clear_q; endproperty
   a_csync: assert property (p_csync) else $error("clocked clear missed");
   property p_psync; !PRE_NOW && ewr && !sh_reg[9] |-> ##2 preset_q; endproperty
   a_psync: assert property (p_psync) else $error("clocked preset missed");
endmodule // cdff_bank_monitor
bind cdff_bank cdff_bank_monitor #(.CLEAR_TIMING(CLEAR_TIMING), .PRESET_TIMING(PRESET_TIMING)) u_cdff_bank_monitor (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .plain_q, .gate_q, .clear_q, .preset_q);
`default_nettype wire

// >>> dv/cdff_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cdff_bank_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic plain_q, gate_q, clear_q, preset_q;
   // Second bank: clocked clear and preset, plain, gate and preset power-up values flipped
   logic [31:0] prdata_b;
   logic pready_b, pslverr_b, plain_q_b, gate_q_b, clear_q_b, preset_q_b;
   logic [3:0] eq, eq2;
   logic [65:0] exp_q[$];
   int error_cnt = 0;
   int samples_checked = 0;
   cdff_bank #(
      .CLEAR_POWER_UP(1'b1)
   ) u_cdff_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .plain_q, .gate_q, .clear_q, .preset_q);
   cdff_bank #(
      .PLAIN_POWER_UP(1'b1),
      .GATE_POWER_UP(1'b1),
      .CLEAR_POWER_UP(1'b1),
      .PRESET_POWER_UP(1'b0),
      .CLEAR_TIMING("clocked"),
      .PRESET_TIMING("clocked")
   ) u_cdff_bank_sync (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(prdata_b),
      .pready(pready_b), .pslverr(pslverr_b), .plain_q(plain_q_b), .gate_q(gate_q_b), .clear_q(clear_q_b),
      .preset_q(preset_q_b));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic bad(input string m);
      $display("BAD %0t %s", $time, m);
      error_cnt++;
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp_q;
      samples_checked++;
      if ({preset_q, clear_q, gate_q, plain_q} !== eq) bad("flop outputs");
      if ({preset_q_b, clear_q_b, gate_q_b, plain_q_b} !== eq2) bad("clocked flop outputs");
   endtask
   // Note layout: check data, expected error, data of second bank, data of first bank
   task automatic cmp_rd(input logic [65:0] e);
      samples_checked++;
      if (pready_b !== 1'b1 || pslverr !== e[64] || pslverr_b !== e[64]) bad("bus status");
      else if (e[65] && (prdata !== e[31:0] || prdata_b !== e[63:32])) bad("bus data");
   endtask
   // Flop values after one sample edge with control word c
   function automatic logic [3:0] nxt(input logic [31:0] c, input logic [3:0] e);
      nxt[0] = c[0];
      nxt[1] = c[4] ? c[1] : e[1];
      nxt[2] = !c[8] ? 1'b0 : c[5] ? c[2] : e[2];
      nxt[3] = !c[9] ? 1'b1 : c[6] ? c[3] : e[3];
   endfunction
   // Each answer is judged against the oldest note
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) bad("stray answer");
         else cmp_rd(exp_q.pop_front());
      end
   end
   // Reads pass the expected word as d; write data on a read is ignored
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] d2,
      input logic ck, input logic er);
      int n;
      exp_q.push_back({ck, er, d2, d});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      if (pready !== 1'b1) begin
         bad("no ready");
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // The clocked bank must not move before the sample edge
   task automatic step(input logic [31:0] c);
      apb(1'b1, 12'h000, c, c, 1'b0, 1'b0);
      if (!c[8]) eq[2] = 1'b0;
      if (!c[9]) eq[3] = 1'b1;
      @(posedge pclk);
      cmp_q();
      apb(1'b1, 12'h004, 32'h0000_0001, 32'h0000_0001, 1'b0, 1'b0);
      eq = nxt(c, eq);
      eq2 = nxt(c, eq2);
      @(posedge pclk);
      cmp_q();
      apb(1'b0, 12'h00C, {28'h000_0000, eq}, {28'h000_0000, eq2}, 1'b1, 1'b0);
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      eq = 4'hC;
      eq2 = 4'h7;
      void'($urandom(32'hc2adfe88));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp_q();
      apb(1'b0, 12'h000, 32'h0000_0300, 32'h0000_0300, 1'b1, 1'b0);
      apb(1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1, 1'b1);
      apb(1'b1, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b1);
      apb(1'b1, 12'h000, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0, 1'b0);
      apb(1'b0, 12'h000, 32'h0000_037F, 32'h0000_037F, 1'b1, 1'b0);
      apb(1'b0, 12'h004, 32'h0000_0000, 32'h0000_0000, 1'b1, 1'b0);
      apb(1'b1, 12'h00C, 32'h0000_000F, 32'h0000_000F, 1'b0, 1'b0);
      apb(1'b0, 12'h00C, {28'h000_0000, eq}, {28'h000_0000, eq2}, 1'b1, 1'b0);
      $display("reset and map done");
      repeat (8) step($urandom & 32'h0000_037F);
      $display("random loads done");
      step(32'h0000_027F);
      step(32'h0000_0200);
      step(32'h0000_0370);
      step(32'h0000_0100);
      $display("clear and preset done");
      apb(1'b1, 12'h000, 32'h0000_0375, 32'h0000_0375, 1'b0, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_0003, 32'h0000_0003, 1'b0, 1'b0);
      apb(1'b0, 12'h008, 32'h0000_0003, 32'h0000_0003, 1'b1, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0);
      eq = nxt(32'h0000_0375, eq);
      eq2 = nxt(32'h0000_0375, eq2);
      @(posedge pclk);
      cmp_q();
      $display("divider done");
      presetn <= 1'b0;
      eq = 4'hC;
      eq2 = 4'h7;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp_q();
      apb(1'b0, 12'h000, 32'h0000_0300, 32'h0000_0300, 1'b1, 1'b0);
      $display("second reset done");
      complete_run();
   end
endmodule // cdff_bank_tb_top
`default_nettype wire
